// *** hw/hbd_map.svh ***
// register map, field positions, reset values and timing constants for headset detect
// Overview of operation
// - headset detection runs only while the enable bit is 1, which is cleared at reset.
// - the headset type reads 00 none, 01 headset without mic, 11 headset with mic; 10 never.
// - jack debounce codes 000 to 101 select 16 to 512 ms with a 2 ms to 64 ms sampling tick.
// - button debounce 00 is none, 01 is 8 ms on 1 ms, 10 is 16 ms on 2 ms, 11 is 32 ms on 4 ms.
// - the button flag sets on a debounced press, holds after release, clears on status read.
// - the read-only headset flag is 1 while a headset is detected and 0 otherwise.
// - the coupling bit selects capless outputs at 0, its reset value, and ac-coupled at 1.
// - configuration bit a at 1 selects the stereo fully differential output arrangement.
// - configuration bit b at 1 selects the stereo pseudodifferential output arrangement.
// - the three low status bits are reserved, read as 000 and take only zero writes.
`ifndef HBD_MAP_SVH
`define HBD_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define HBD_ADDR_CTRL     8'h0d
`define HBD_ADDR_STAT     8'h0e
`define HBD_RD_IDLE       8'h00

// ****************************************
// control register fields
// ****************************************
`define HBD_C_ENABLE      7
`define HBD_C_TYPE_HI     6
`define HBD_C_TYPE_LO     5
`define HBD_C_JDEB_HI     4
`define HBD_C_JDEB_LO     2
`define HBD_C_BDEB_HI     1
`define HBD_C_BDEB_LO     0

// ****************************************
// status and driver register fields
// ****************************************
`define HBD_S_COUPLE      7
`define HBD_S_FDIFF       6
`define HBD_S_BTN         5
`define HBD_S_HSET        4
`define HBD_S_PDIFF       3
`define HBD_S_RSV_HI      2
`define HBD_S_RSV_LO      0
`define HBD_S_RSV_VAL     3'h0

// ****************************************
// reset values
// ****************************************
`define HBD_RST_BIT       1'h0
`define HBD_RST_JDEB      3'h0
`define HBD_RST_BDEB      2'h0

// ****************************************
// debounce codes and channels
// ****************************************
`define HBD_JDEB_MAX      3'h5
`define HBD_JDEB_EXP_OFS  3'h1
`define HBD_BDEB_OFF      2'h0
`define HBD_TICK_LAST     3'h7
`define HBD_CH_JACK       0
`define HBD_CH_MIC        1
`define HBD_CH_BTN        2
`define HBD_CH_NUM        3

// ****************************************
// timing
// ****************************************
`define HBD_CLK_PERIOD_NS 5
`define HBD_MS_NS         1000000
`define HBD_MS_CYCLES     (`HBD_MS_NS / `HBD_CLK_PERIOD_NS)
`define HBD_DIV_W         18
`define HBD_MSCNT_W       6

`endif

// *** hw/hbd_pkg.sv ***
// types shared by the headset detect block
package hbd_pkg;
   typedef enum logic [1:0] {
      HBD_TYPE_NONE  = 2'b00,
      HBD_TYPE_NOMIC = 2'b01,
      HBD_TYPE_MIC   = 2'b11
   } hbd_type_t;
   typedef logic [2:0] hbd_jdeb_t;
   typedef logic [1:0] hbd_bdeb_t;
   typedef logic [2:0] hbd_exp_t;
endpackage

// *** hw/hbd_deb_if.sv ***
// carrier between the detect control and one debounce channel
`timescale 1ns/1ps
`default_nettype none
interface hbd_deb_if;
   logic ce;
   logic tick;
   logic bypass;
   logic clear;
   logic raw;
   logic stable;
   modport ctl (output ce, output tick, output bypass, output clear, output raw, input stable);
   modport deb (input ce, input tick, input bypass, input clear, input raw, output stable);
endinterface
`default_nettype wire

// *** hw/hbd_debounce.sv ***
// one debounce channel: accepts a change after eight stable ticks
`timescale 1ns/1ps
`default_nettype none
`include "hbd_map.svh"
module hbd_debounce
   import hbd_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // channel carrier
   hbd_deb_if.deb    d
);
   logic       stable_r;
   logic [2:0] cnt_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stable_r <= `HBD_RST_BIT;
         cnt_r    <= 3'h0;
      end else if (d.ce) begin
         if (d.clear) begin
            stable_r <= `HBD_RST_BIT;
            cnt_r    <= 3'h0;
         end else if (d.bypass) begin
            stable_r <= d.raw;
            cnt_r    <= 3'h0;
         end else if (d.raw == stable_r) begin
            cnt_r <= 3'h0;
         end else if (d.tick) begin
            if (cnt_r == `HBD_TICK_LAST) begin
               stable_r <= d.raw;
               cnt_r    <= 3'h0;
            end else begin
               cnt_r <= cnt_r + 3'h1;
            end
         end
      end
   end

   assign d.stable = stable_r;
endmodule
`default_nettype wire

// *** hw/hbd_top.sv ***
// headset and button press detection with driver configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "hbd_map.svh"
module hbd_top
   import hbd_pkg::*;
#(
   parameter int MS_CYCLES = `HBD_MS_CYCLES
)(
   // clock, reset, enable
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       ce,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_strobe,
   input  wire logic       rd_strobe,
   output logic      [7:0] rd_data,
   // analog comparators
   input  wire logic       jack_sense,
   input  wire logic       mic_sense,
   input  wire logic       button_sense,
   // configuration and status outputs
   output logic            detect_enable,
   output logic            drv_ac_coupled,
   output logic            drv_fully_diff,
   output logic            drv_pseudo_diff,
   output logic      [1:0] headset_type,
   output logic            button_flag
);

   // ****************************************
   // registers
   // ****************************************
   logic                   en_r;
   hbd_jdeb_t              jdeb_r;
   hbd_bdeb_t              bdeb_r;
   logic                   couple_r;
   logic                   fdiff_r;
   logic                   pdiff_r;
   hbd_type_t              type_r;
   logic                   btn_flag_r;
   logic                   btn_prev_r;
   logic [7:0]             rd_data_r;
   logic [`HBD_DIV_W-1:0]  div_r;
   logic [`HBD_MSCNT_W-1:0] ms_cnt_r;
   logic                   ms_tick_r;

   // ****************************************
   // decode helpers
   // ****************************************
   logic                   wr_ctrl;
   logic                   wr_stat;
   logic                   rd_stat;
   logic                   jtick;
   logic                   btick;
   logic                   btn_set;
   logic [`HBD_CH_NUM-1:0] raw_vec;
   logic [`HBD_CH_NUM-1:0] tick_vec;
   logic [`HBD_CH_NUM-1:0] byp_vec;
   logic [`HBD_CH_NUM-1:0] stable_vec;
   logic [7:0]             ctrl_view;
   logic [7:0]             stat_view;
   hbd_type_t              type_nxt;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // tick of 2**e ms, aligned on the free running millisecond counter
   function automatic logic tick_of(input logic t, input logic [`HBD_MSCNT_W-1:0] c,
                                    input hbd_exp_t e);
      logic [`HBD_MSCNT_W-1:0] mask;
      mask    = '0;
      mask    = ~({`HBD_MSCNT_W{1'b1}} << e);
      tick_of = t && ((c & mask) == mask);
   endfunction

   assign wr_ctrl = ce && wr_strobe && hit(addr, `HBD_ADDR_CTRL);
   assign wr_stat = ce && wr_strobe && hit(addr, `HBD_ADDR_STAT);
   assign rd_stat = ce && rd_strobe && hit(addr, `HBD_ADDR_STAT);

   // ****************************************
   // millisecond time base
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_r     <= '0;
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b0;
      end else if (ce) begin
         if (div_r == `HBD_DIV_W'(MS_CYCLES - 1)) begin
            div_r     <= '0;
            ms_cnt_r  <= ms_cnt_r + `HBD_MSCNT_W'(1);
            ms_tick_r <= 1'b1;
         end else begin
            div_r     <= div_r + `HBD_DIV_W'(1);
            ms_tick_r <= 1'b0;
         end
      end
   end

   // jack tick doubles from 2 ms, reserved codes clamp to the longest
   assign jtick = tick_of(ms_tick_r, ms_cnt_r,
                          (jdeb_r > `HBD_JDEB_MAX ? `HBD_JDEB_MAX : jdeb_r)
                          + `HBD_JDEB_EXP_OFS);
   // button tick is 1, 2 or 4 ms, code zero bypasses
   assign btick = tick_of(ms_tick_r, ms_cnt_r,
                          hbd_exp_t'(bdeb_r) - hbd_exp_t'(1));

   // ****************************************
   // debounce channels
   // ****************************************
   assign raw_vec[`HBD_CH_JACK]  = jack_sense;
   assign raw_vec[`HBD_CH_MIC]   = mic_sense;
   assign raw_vec[`HBD_CH_BTN]   = button_sense;
   assign tick_vec[`HBD_CH_JACK] = jtick;
   assign tick_vec[`HBD_CH_MIC]  = jtick;
   assign tick_vec[`HBD_CH_BTN]  = btick;
   assign byp_vec[`HBD_CH_JACK]  = 1'b0;
   assign byp_vec[`HBD_CH_MIC]   = 1'b0;
   assign byp_vec[`HBD_CH_BTN]   = (bdeb_r == `HBD_BDEB_OFF);

   for (genvar g = 0; g < `HBD_CH_NUM; g++) begin : g_ch
      hbd_deb_if u_if ();
      assign u_if.ce     = ce;
      assign u_if.tick   = tick_vec[g];
      assign u_if.bypass = byp_vec[g];
      assign u_if.clear  = !en_r;
      assign u_if.raw    = raw_vec[g];
      assign stable_vec[g] = u_if.stable;
      hbd_debounce u_deb (
         .clk_sys (clk_sys),
         .reset   (reset),
         .d       (u_if.deb)
      );
   end

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         en_r   <= `HBD_RST_BIT;
         jdeb_r <= `HBD_RST_JDEB;
         bdeb_r <= `HBD_RST_BDEB;
      end else if (wr_ctrl) begin
         en_r   <= wr_data[`HBD_C_ENABLE];
         jdeb_r <= wr_data[`HBD_C_JDEB_HI:`HBD_C_JDEB_LO];
         bdeb_r <= wr_data[`HBD_C_BDEB_HI:`HBD_C_BDEB_LO];
      end
   end

   // ****************************************
   // driver configuration register
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         couple_r <= `HBD_RST_BIT;
         fdiff_r  <= `HBD_RST_BIT;
         pdiff_r  <= `HBD_RST_BIT;
      end else if (wr_stat) begin
         couple_r <= wr_data[`HBD_S_COUPLE];
         fdiff_r  <= wr_data[`HBD_S_FDIFF];
         pdiff_r  <= wr_data[`HBD_S_PDIFF];
      end
   end

   // ****************************************
   // headset type
   // ****************************************
   always_comb begin
      type_nxt = HBD_TYPE_NONE;
      if (en_r && stable_vec[`HBD_CH_JACK]) begin
         type_nxt = stable_vec[`HBD_CH_MIC] ? HBD_TYPE_MIC : HBD_TYPE_NOMIC;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         type_r <= HBD_TYPE_NONE;
      end else if (ce) begin
         type_r <= type_nxt;
      end
   end

   // ****************************************
   // button press flag
   // ****************************************
   assign btn_set = ce && en_r && stable_vec[`HBD_CH_BTN] && !btn_prev_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         btn_prev_r <= `HBD_RST_BIT;
      end else if (ce) begin
         btn_prev_r <= stable_vec[`HBD_CH_BTN];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         btn_flag_r <= `HBD_RST_BIT;
      end else if (btn_set) begin
         btn_flag_r <= 1'b1;
      end else if (rd_stat) begin
         btn_flag_r <= 1'b0;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_comb begin
      ctrl_view = '0;
      ctrl_view[`HBD_C_ENABLE] = en_r;
      ctrl_view[`HBD_C_TYPE_HI:`HBD_C_TYPE_LO] = type_r;
      ctrl_view[`HBD_C_JDEB_HI:`HBD_C_JDEB_LO] = jdeb_r;
      ctrl_view[`HBD_C_BDEB_HI:`HBD_C_BDEB_LO] = bdeb_r;
      stat_view = '0;
      stat_view[`HBD_S_COUPLE] = couple_r;
      stat_view[`HBD_S_FDIFF]  = fdiff_r;
      stat_view[`HBD_S_BTN]    = btn_flag_r;
      stat_view[`HBD_S_HSET]   = (type_r != HBD_TYPE_NONE);
      stat_view[`HBD_S_PDIFF]  = pdiff_r;
      stat_view[`HBD_S_RSV_HI:`HBD_S_RSV_LO] = `HBD_S_RSV_VAL;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_data_r <= `HBD_RD_IDLE;
      end else if (ce) begin
         if (rd_strobe && hit(addr, `HBD_ADDR_CTRL)) begin
            rd_data_r <= ctrl_view;
         end else if (rd_strobe && hit(addr, `HBD_ADDR_STAT)) begin
            rd_data_r <= stat_view;
         end else begin
            rd_data_r <= `HBD_RD_IDLE;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign rd_data         = rd_data_r;
   assign detect_enable   = en_r;
   assign drv_ac_coupled  = couple_r;
   assign drv_fully_diff  = fdiff_r;
   assign drv_pseudo_diff = pdiff_r;
   assign headset_type    = type_r;
   assign button_flag     = btn_flag_r;

   // ****************************************
   // checks
   // ****************************************
   chk_disable_idle: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && !en_r) |=> (type_r == HBD_TYPE_NONE))
      else $error("type not none while detection disabled");

   chk_type_legal: assert property (@(posedge clk_sys) disable iff (reset)
      type_r != 2'b10)
      else $error("illegal headset type");

   chk_type_follow: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && en_r && stable_vec[`HBD_CH_JACK]) |=>
      (type_r[0] && type_r[1] == $past(stable_vec[`HBD_CH_MIC])))
      else $error("headset type does not follow debounced inputs");

   chk_jack_on_tick: assert property (@(posedge clk_sys) disable iff (reset)
      ($changed(stable_vec[`HBD_CH_JACK]) && $past(en_r) && $past(ce))
      |-> $past(jtick) && $past(jack_sense) == stable_vec[`HBD_CH_JACK])
      else $error("jack change accepted off tick");

   chk_button_bypass: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && en_r && bdeb_r == `HBD_BDEB_OFF) |=> stable_vec[`HBD_CH_BTN] == $past(button_sense))
      else $error("button not passed through with debounce off");

   chk_btn_sticky: assert property (@(posedge clk_sys) disable iff (reset)
      (btn_flag_r && !rd_stat) |=> btn_flag_r)
      else $error("button flag dropped without read");

   chk_btn_clear: assert property (@(posedge clk_sys) disable iff (reset)
      (rd_stat && !btn_set) |=> !btn_flag_r ##0 rd_data_r[`HBD_S_BTN] == $past(btn_flag_r))
      else $error("button flag not cleared by read");

   chk_hset_flag: assert property (@(posedge clk_sys) disable iff (reset)
      rd_stat |=> rd_data_r[`HBD_S_HSET] == ($past(type_r) != HBD_TYPE_NONE))
      else $error("headset flag mismatch");

   chk_cfg_write: assert property (@(posedge clk_sys) disable iff (reset)
      wr_stat |=> {couple_r, fdiff_r, pdiff_r} ==
      {$past(wr_data[`HBD_S_COUPLE]), $past(wr_data[`HBD_S_FDIFF]), $past(wr_data[`HBD_S_PDIFF])})
      else $error("driver configuration not written");

   chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
      rd_stat |=> rd_data_r[`HBD_S_RSV_HI:`HBD_S_RSV_LO] == `HBD_S_RSV_VAL)
      else $error("reserved status bits not zero");

   chk_ro_type: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_ctrl && $stable(stable_vec) && $stable(en_r)) |=> $stable(type_r))
      else $error("type field changed by write");

   chk_disable_clear: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && !en_r) |=> (stable_vec == '0))
      else $error("debounce state kept while detection disabled");

   chk_no_press_off: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && !en_r && !btn_flag_r) |=> !btn_flag_r)
      else $error("button flag set while detection disabled");

   chk_btn_set: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && en_r && stable_vec[`HBD_CH_BTN] && !btn_prev_r) |=> btn_flag_r)
      else $error("button flag not set on press");

   chk_ctrl_write: assert property (@(posedge clk_sys) disable iff (reset)
      wr_ctrl |=> (en_r == $past(wr_data[`HBD_C_ENABLE])) &&
      (jdeb_r == $past(wr_data[`HBD_C_JDEB_HI:`HBD_C_JDEB_LO])) &&
      (bdeb_r == $past(wr_data[`HBD_C_BDEB_HI:`HBD_C_BDEB_LO])))
      else $error("control register not written");

   chk_ctrl_view: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && rd_strobe && hit(addr, `HBD_ADDR_CTRL)) |=>
      (rd_data_r[`HBD_C_TYPE_HI:`HBD_C_TYPE_LO] == $past(type_r)))
      else $error("type field not shown on control read");

   chk_jack_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && en_r && !jtick) |=> $stable(stable_vec[`HBD_CH_JACK]))
      else $error("jack state changed without a sampling tick");

   chk_mic_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && en_r && !jtick) |=> $stable(stable_vec[`HBD_CH_MIC]))
      else $error("mic state changed without a sampling tick");

   chk_btn_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (ce && en_r && bdeb_r != `HBD_BDEB_OFF && !btick) |=> $stable(stable_vec[`HBD_CH_BTN]))
      else $error("button state changed without a sampling tick");

   chk_stat_ro: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_stat && !btn_set && !rd_stat) |=> $stable(btn_flag_r))
      else $error("button flag changed by write");

   chk_jtick_align: assert property (@(posedge clk_sys) disable iff (reset)
      jtick |-> (ms_tick_r && ms_cnt_r[0]))
      else $error("jack tick shorter than two milliseconds");

endmodule
`default_nettype wire

// *** verif/hbd_sense_model.sv ***
// comparator model for jack, microphone and button sensing
`timescale 1ns/1ps
`default_nettype none
module hbd_sense_model (
   // clock
   input  wire logic clk_sys,
   // comparator levels
   output logic      jack_sense,
   output logic      mic_sense,
   output logic      button_sense
);
   initial begin
      jack_sense   = 1'b0;
      mic_sense    = 1'b0;
      button_sense = 1'b0;
   end

   // ****************************************
   // level changes just after a clock edge
   // ****************************************
   task automatic drive(input logic j, input logic m, input logic b);
      @(posedge clk_sys);
      jack_sense   <= j;
      mic_sense    <= m & j;
      button_sense <= b;
   endtask
endmodule
`default_nettype wire

// *** verif/tb_headset_button_detect.sv ***
// self-checking bench for the headset and button detect block
`timescale 1ns/1ps
`default_nettype none
`include "hbd_map.svh"
module tb_headset_button_detect
   import hbd_pkg::*;
;
   localparam int MS = 4;
   logic       clk_sys;
   logic       reset;
   logic       ce;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic       wr_strobe;
   logic       rd_strobe;
   logic [7:0] rd_data;
   logic       jack_sense;
   logic       mic_sense;
   logic       button_sense;
   logic       detect_enable;
   logic       drv_ac_coupled;
   logic       drv_fully_diff;
   logic       drv_pseudo_diff;
   logic [1:0] headset_type;
   logic       button_flag;
   logic [7:0] d;
   logic [7:0] tbl [3] = '{8'hb0, 8'h40, 8'h08};
   logic [7:0] exv [3] = '{8'h80, 8'h40, 8'h08};
   int         error_cnt = 0;
   int         checks_done = 0;
   int         n;
   int         p;

   always #2.5 clk_sys = ~clk_sys;

   hbd_top #(.MS_CYCLES(MS)) DUT (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .jack_sense(jack_sense), .mic_sense(mic_sense), .button_sense(button_sense),
      .detect_enable(detect_enable), .drv_ac_coupled(drv_ac_coupled),
      .drv_fully_diff(drv_fully_diff), .drv_pseudo_diff(drv_pseudo_diff),
      .headset_type(headset_type), .button_flag(button_flag)
   );

   hbd_sense_model u_sense (
      .clk_sys(clk_sys), .jack_sense(jack_sense), .mic_sense(mic_sense),
      .button_sense(button_sense)
   );

   // ****************************************
   // report, compare and bus tasks
   // ****************************************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr      <= a;
      wr_data   <= v;
      wr_strobe <= 1'b1;
      @(posedge clk_sys);
      wr_strobe <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      addr      <= a;
      rd_strobe <= 1'b1;
      @(posedge clk_sys);
      rd_strobe <= 1'b0;
      #1;
      v = rd_data;
      @(posedge clk_sys);
      #1;
      check(rd_data, 8'h00);
   endtask

   // bounded wait on type (sel 0) or button flag (sel 1)
   task automatic wait_val(input int sel, input logic [1:0] exp, input int lim, output int cnt);
      cnt = 0;
      #1;
      while (cnt < lim && (sel != 0 ? {1'b0, button_flag} : headset_type) !== exp) begin
         @(posedge clk_sys);
         #1;
         cnt++;
      end
      if (cnt >= lim) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time,
                  (sel != 0 ? {1'b0, button_flag} : headset_type), exp);
         wrap_up();
      end
   endtask

   task automatic in_range(input int v, input int lo, input int hi);
      check({7'h0, v >= lo && v <= hi}, 8'h01);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      clk_sys   = 1'b0;
      reset     = 1'b1;
      ce        = 1'b1;
      addr      = 8'h00;
      wr_data   = 8'h00;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      rd(`HBD_ADDR_CTRL, d);
      check(d, 8'h00);
      rd(`HBD_ADDR_STAT, d);
      check(d, 8'h00);
      wr(8'h0f, 8'hff);
      rd(8'h0f, d);
      check(d, 8'h00);
      wr(`HBD_ADDR_CTRL, 8'h60);
      rd(`HBD_ADDR_CTRL, d);
      check(d, 8'h00);
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(`HBD_ADDR_CTRL, 8'h80);
      ce <= 1'b1;
      rd(`HBD_ADDR_CTRL, d);
      check(d, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(`HBD_ADDR_STAT, tbl[i]);
         rd(`HBD_ADDR_STAT, d);
         check(d, exv[i]);
         check({5'h0, drv_ac_coupled, drv_fully_diff, drv_pseudo_diff},
               {5'h0, exv[i][7], exv[i][6], exv[i][3]});
      end
      wr(`HBD_ADDR_STAT, 8'h00);
      $display("test registers done");
      u_sense.drive(1'b1, 1'b1, 1'b1);
      repeat (600) @(posedge clk_sys);
      #1;
      check({6'h0, headset_type}, 8'h00);
      check({7'h0, button_flag}, 8'h00);
      u_sense.drive(1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge clk_sys);
      $display("test disabled done");
      for (int c = 0; c < 6; c++) begin
         p = (8 << c) * MS / 4;
         wr(`HBD_ADDR_CTRL, 8'h80 | 8'(c << 2));
         #1;
         check({7'h0, detect_enable}, 8'h01);
         u_sense.drive(1'b1, 1'b1, 1'b0);
         wait_val(0, HBD_TYPE_MIC, 8 * p + 6, n);
         in_range(n, 7 * p - 2, 8 * p + 4);
         rd(`HBD_ADDR_STAT, d);
         check(d, 8'h10);
         u_sense.drive(1'b0, 1'b0, 1'b0);
         wait_val(0, HBD_TYPE_NONE, 8 * p + 6, n);
         in_range(n, 7 * p - 2, 8 * p + 4);
      end
      u_sense.drive(1'b1, 1'b0, 1'b0);
      wait_val(0, HBD_TYPE_NOMIC, 8 * p + 6, n);
      u_sense.drive(1'b1, 1'b1, 1'b0);
      wait_val(0, HBD_TYPE_MIC, 8 * p + 6, n);
      in_range(n, 7 * p - 2, 8 * p + 4);
      wr(`HBD_ADDR_CTRL, 8'h00);
      wait_val(0, HBD_TYPE_NONE, 4, n);
      u_sense.drive(1'b0, 1'b0, 1'b0);
      $display("test jack done");
      for (int b = 0; b < 4; b++) begin
         p = (b == 0) ? 0 : (MS << (b - 1));
         wr(`HBD_ADDR_CTRL, 8'h80 | 8'(b));
         u_sense.drive(1'b0, 1'b0, 1'b1);
         wait_val(1, 2'b01, 8 * p + 6, n);
         in_range(n, (b == 0) ? 0 : 7 * p - 2, (b == 0) ? 3 : 8 * p + 4);
         u_sense.drive(1'b0, 1'b0, 1'b0);
         repeat (8 * p + 8) @(posedge clk_sys);
         #1;
         check({7'h0, button_flag}, 8'h01);
         rd(`HBD_ADDR_STAT, d);
         check(d, 8'h20);
         check({7'h0, button_flag}, 8'h00);
         rd(`HBD_ADDR_STAT, d);
         check(d, 8'h00);
      end
      $display("test button done");
      wrap_up();
   end
endmodule
`default_nettype wire
